// >>> pkg/cpr_pkg.sv
// package for the core pointer register bank: offsets, reset values, carriers
// assumes an 8-bit special-register access port driven by the core execution logic
package cpr_pkg;

	// special-register addresses of the pointer bank
	localparam logic [7:0] CPR_ADDR_STACK_TOP = 8'h81;
	localparam logic [7:0] CPR_ADDR_PTR_LOW   = 8'h82;
	localparam logic [7:0] CPR_ADDR_PTR_HIGH  = 8'h83;

	// values after reset
	localparam logic [7:0] CPR_RST_STACK_TOP  = 8'h07;
	localparam logic [7:0] CPR_RST_PTR_LOW    = 8'h00;
	localparam logic [7:0] CPR_RST_PTR_HIGH   = 8'h00;

	// answer for an unassigned address
	localparam logic [7:0] CPR_RESERVED_READ  = 8'h00;

	// stack step per push or pop
	localparam logic [7:0] CPR_STACK_STEP     = 8'h01;

	// special-register access request from the core
	typedef struct packed {
		logic       wr;    // write strobe
		logic       rd;    // read strobe
		logic [7:0] addr;  // special-register address
		logic [7:0] wdata; // write data
	} cpr_sreg_req_t;

	// stack operation request from the core
	typedef struct packed {
		logic push; // increment before the byte is written
		logic pop;  // byte read at old index, then decrement
	} cpr_stack_req_t;

endpackage : cpr_pkg

// >>> core/cpr_pointer_regs.sv
// core pointer register bank: stack top index and 16-bit data pointer
// assumes the core drives one register access or stack operation per cycle,
// synchronous to REF_CLK_I; no inputs cross a clock domain
`timescale 1ns/100ps

// Functional notes
// - stack index incremented before each push
// - stack index resets to 0x07
// - low byte forms pointer bits 7..0
// - high byte at 0x83, bits 15..8
// - pointer addresses external RAM and flash
// - unassigned addresses do nothing, read zero
module cpr_pointer_regs
	import cpr_pkg::*;
(
	input  wire logic           REF_CLK_I,        // core system clock, 100 MHz
	input  wire logic           RESET_I,          // synchronous, active high
	input  wire cpr_sreg_req_t  SREG_REQ_I,       // register access from the core
	input  wire cpr_stack_req_t STACK_REQ_I,      // push / pop request
	output logic [7:0]          SREG_RDATA_O,     // registered read data
	output logic                SREG_HIT_O,       // registered: read in the previous cycle hit a pointer register
	output logic [7:0]          STACK_ADDR_O,     // registered stack access address
	output logic                STACK_WR_O,       // registered: push byte write strobe
	output logic                STACK_RD_O,       // registered: pop byte read strobe
	output logic [15:0]         DATA_POINTER_16_O // registered indirect address
);

	////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0]  stack_top_index_ff;   // top of stack
	logic [7:0]  nxt_stack_top_index;
	logic [7:0]  pointer_low_byte_ff;  // data pointer low byte
	logic [7:0]  nxt_pointer_low_byte;
	logic [7:0]  pointer_high_byte_ff; // data pointer high byte
	logic [7:0]  nxt_pointer_high_byte;
	logic [7:0]  rdata_ff;             // read data
	logic [7:0]  nxt_rdata;
	logic        hit_ff;               // read hit flag
	logic        nxt_hit;
	logic [7:0]  stack_addr_ff;        // stack access address
	logic [7:0]  nxt_stack_addr;
	logic        stack_wr_ff;          // push strobe
	logic        nxt_stack_wr;
	logic        stack_rd_ff;          // pop strobe
	logic        nxt_stack_rd;
	logic [15:0] data_pointer_16_ff;              // registered data pointer
	logic [15:0] nxt_data_pointer_16;

	////////////////////////////////////////////////////////////////////////
	// next-state logic; a register write takes priority over a stack op
	// in the same cycle, since software loading the index is explicit
	always_comb
	begin
		nxt_stack_top_index   = stack_top_index_ff;
		nxt_pointer_low_byte  = pointer_low_byte_ff;
		nxt_pointer_high_byte = pointer_high_byte_ff;
		nxt_rdata             = rdata_ff;
		nxt_hit               = 1'b0;
		nxt_stack_addr        = stack_addr_ff;
		nxt_stack_wr          = 1'b0;
		nxt_stack_rd          = 1'b0;

		if (STACK_REQ_I.push)
		begin
			nxt_stack_top_index = stack_top_index_ff + CPR_STACK_STEP;
			nxt_stack_addr      = stack_top_index_ff + CPR_STACK_STEP;
			nxt_stack_wr        = 1'b1;
		end
		else if (STACK_REQ_I.pop)
		begin
			nxt_stack_addr      = stack_top_index_ff;
			nxt_stack_top_index = stack_top_index_ff - CPR_STACK_STEP;
			nxt_stack_rd        = 1'b1;
		end

		// register writes; all eight bits are implemented, so reserved-bit
		// care by software does not apply to these registers
		if (SREG_REQ_I.wr)
		begin
			unique case (SREG_REQ_I.addr)
				CPR_ADDR_STACK_TOP: nxt_stack_top_index = SREG_REQ_I.wdata;
				CPR_ADDR_PTR_LOW:   nxt_pointer_low_byte = SREG_REQ_I.wdata;
				CPR_ADDR_PTR_HIGH:  nxt_pointer_high_byte = SREG_REQ_I.wdata;
				default:            ;
			endcase
		end

		// register reads
		if (SREG_REQ_I.rd)
		begin
			nxt_hit = 1'b1;
			unique case (SREG_REQ_I.addr)
				CPR_ADDR_STACK_TOP: nxt_rdata = stack_top_index_ff;
				CPR_ADDR_PTR_LOW:   nxt_rdata = pointer_low_byte_ff;
				CPR_ADDR_PTR_HIGH:  nxt_rdata = pointer_high_byte_ff;
				default:
				begin
					nxt_rdata = CPR_RESERVED_READ;
					nxt_hit   = 1'b0;
				end
			endcase
		end

		nxt_data_pointer_16 = {nxt_pointer_high_byte, nxt_pointer_low_byte};
	end

	////////////////////////////////////////////////////////////////////////
	// registers only
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
		begin
			stack_top_index_ff   <= CPR_RST_STACK_TOP;
			pointer_low_byte_ff  <= CPR_RST_PTR_LOW;
			pointer_high_byte_ff <= CPR_RST_PTR_HIGH;
			rdata_ff             <= CPR_RESERVED_READ;
			hit_ff               <= 1'b0;
			stack_addr_ff        <= CPR_RST_STACK_TOP;
			stack_wr_ff          <= 1'b0;
			stack_rd_ff          <= 1'b0;
			data_pointer_16_ff              <= {CPR_RST_PTR_HIGH, CPR_RST_PTR_LOW};
		end
		else
		begin
			stack_top_index_ff   <= nxt_stack_top_index;
			pointer_low_byte_ff  <= nxt_pointer_low_byte;
			pointer_high_byte_ff <= nxt_pointer_high_byte;
			rdata_ff             <= nxt_rdata;
			hit_ff               <= nxt_hit;
			stack_addr_ff        <= nxt_stack_addr;
			stack_wr_ff          <= nxt_stack_wr;
			stack_rd_ff          <= nxt_stack_rd;
			data_pointer_16_ff              <= nxt_data_pointer_16;
		end
	end

	// outputs straight from flip-flops
	assign SREG_RDATA_O      = rdata_ff;
	assign SREG_HIT_O        = hit_ff;
	assign STACK_ADDR_O      = stack_addr_ff;
	assign STACK_WR_O        = stack_wr_ff;
	assign STACK_RD_O        = stack_rd_ff;
	assign DATA_POINTER_16_O = data_pointer_16_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RESET_I);

	sequence push_only_s;
		STACK_REQ_I.push && !SREG_REQ_I.wr;
	endsequence

	sequence pop_only_s;
		STACK_REQ_I.pop && !STACK_REQ_I.push && !SREG_REQ_I.wr;
	endsequence

	push_pre_inc_a: assert property (push_only_s |=>
		STACK_WR_O && STACK_ADDR_O == $past(stack_top_index_ff) + 8'h01
		&& stack_top_index_ff == STACK_ADDR_O)
		else $error("push did not pre-increment stack index");

	pop_post_dec_a: assert property (pop_only_s |=>
		STACK_RD_O && STACK_ADDR_O == $past(stack_top_index_ff)
		&& stack_top_index_ff == STACK_ADDR_O - 8'h01)
		else $error("pop did not read old top then decrement");

	reset_index_a: assert property (@(posedge REF_CLK_I) disable iff (1'b0)
		RESET_I ##1 1'b1 |-> stack_top_index_ff == 8'h07 && DATA_POINTER_16_O == 16'h0000)
		else $error("wrong pointer values after reset");

	low_byte_a: assert property (SREG_REQ_I.wr && SREG_REQ_I.addr == 8'h82 |=>
		DATA_POINTER_16_O[7:0] == $past(SREG_REQ_I.wdata))
		else $error("low pointer byte not in bits 7..0");

	high_byte_a: assert property (SREG_REQ_I.wr && SREG_REQ_I.addr == 8'h83 |=>
		DATA_POINTER_16_O[15:8] == $past(SREG_REQ_I.wdata))
		else $error("high pointer byte not in bits 15..8");

	pointer_join_a: assert property (##1 1'b1 |->
		DATA_POINTER_16_O == {pointer_high_byte_ff, pointer_low_byte_ff})
		else $error("data pointer does not match its bytes");

	reserved_read_a: assert property (SREG_REQ_I.rd && !(SREG_REQ_I.addr inside {8'h81, 8'h82, 8'h83}) |=>
		SREG_RDATA_O == 8'h00 && !SREG_HIT_O)
		else $error("reserved address read returned data");

	reserved_write_a: assert property (SREG_REQ_I.wr && !(SREG_REQ_I.addr inside {8'h81, 8'h82, 8'h83})
		&& !STACK_REQ_I.push && !STACK_REQ_I.pop |=> $stable(stack_top_index_ff)
		&& $stable(DATA_POINTER_16_O))
		else $error("reserved address write changed state");

	// pointer holds between writes
	// any other change would redirect an indirect access behind software's back
	pointer_hold_a: assert property (!(SREG_REQ_I.wr && SREG_REQ_I.addr inside {8'h82, 8'h83}) |=>
		$stable(DATA_POINTER_16_O))
		else $error("data pointer moved without a byte write");

	sequence push_and_pop_s;
		STACK_REQ_I.push && STACK_REQ_I.pop;
	endsequence

	push_wins_a: assert property (push_and_pop_s |=>
		STACK_WR_O && !STACK_RD_O)
		else $error("pop was not dropped under a push");

	sequence index_load_s;
		SREG_REQ_I.wr && SREG_REQ_I.addr == 8'h81;
	endsequence

	index_load_a: assert property (index_load_s |=>
		stack_top_index_ff == $past(SREG_REQ_I.wdata))
		else $error("index write lost to a stack step");

	index_read_a: assert property (SREG_REQ_I.rd && SREG_REQ_I.addr == 8'h81 |=>
		SREG_RDATA_O == $past(stack_top_index_ff) && SREG_HIT_O)
		else $error("index read gave wrong data");

endmodule // cpr_pointer_regs

// >>> test/cpr_stack_mem_model.sv
// model of the stack byte store beside the pointer bank
// assumes strobes are one-cycle pulses on the rising edge
`timescale 1ns/100ps
module cpr_stack_mem_model
	import cpr_pkg::*;
(
	input  wire logic        clk_i,    // core clock
	input  wire logic        rst_i,    // synchronous reset
	input  wire logic        wr_i,     // push byte write
	input  wire logic        rd_i,     // pop byte read
	output logic      [15:0] wr_cnt_o, // writes taken
	output logic      [15:0] rd_cnt_o  // reads answered
);
	////////////////////////////////////////////////////////////
	// counts only, so a lost or doubled strobe shows at the end
	// one byte access per stack op
	always_ff @(posedge clk_i)
	begin
		wr_cnt_o <= rst_i ? 16'h0000 : wr_cnt_o + 16'(wr_i);
		rd_cnt_o <= rst_i ? 16'h0000 : rd_cnt_o + 16'(rd_i);
	end
endmodule // cpr_stack_mem_model

// >>> test/cpr_pointer_regs_tb_top.sv
// bench for the pointer bank: corner cases, then seeded random traffic
// assumes answers settle one cycle after the request edge
`timescale 1ns/100ps
module cpr_pointer_regs_tb_top;
	import cpr_pkg::*;
	logic           clk = 1'b0;       // 100 MHz core clock
	logic           rst = 1'b1;       // synchronous reset
	cpr_sreg_req_t  sreg = '0;        // register access
	cpr_stack_req_t stk = '0;         // stack op
	logic [7:0]     rdata, saddr;     // design answers
	logic           hit, swr, srd;    // one-cycle pulses
	logic [15:0]    data_pointer_16, wn, rn;     // pointer, partner counts
	logic [7:0]     sp, lo, hi, k, v; // expected state, random bytes
	logic [15:0]    pn, qn;           // expected partner counts
	logic [16:0]    lfsr = 17'h15a33; // seed 88627
	int             failures = 0;
	int             samples_checked = 0;

	always #5 clk = ~clk;

	cpr_pointer_regs i_cpr_pointer_regs (.REF_CLK_I(clk), .RESET_I(rst), .SREG_REQ_I(sreg),
		.STACK_REQ_I(stk), .SREG_RDATA_O(rdata), .SREG_HIT_O(hit), .STACK_ADDR_O(saddr),
		.STACK_WR_O(swr), .STACK_RD_O(srd), .DATA_POINTER_16_O(data_pointer_16));
	cpr_stack_mem_model i_cpr_stack_mem_model (.clk_i(clk), .rst_i(rst), .wr_i(swr),
		.rd_i(srd), .wr_cnt_o(wn), .rd_cnt_o(rn));

	////////////////////////////////////////////////////////////
	// eight shifts per byte so successive bytes are not correlated
	function automatic logic [7:0] rnd();
		repeat (8) lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
		return lfsr[7:0];
	endfunction
	// read answer from the bench's own state: {hit, data}
	function automatic logic [8:0] exp_read(input logic [7:0] a);
		case (a)
			CPR_ADDR_STACK_TOP: return {1'b1, sp};
			CPR_ADDR_PTR_LOW:   return {1'b1, lo};
			CPR_ADDR_PTR_HIGH:  return {1'b1, hi};
			default:            return {1'b0, CPR_RESERVED_READ};
		endcase
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one request at a falling edge, answers looked at one cycle later
	task automatic op(input logic w, r, p, q, input logic [7:0] a, d);
		logic [8:0] e;
		logic [7:0] ea;
		e = exp_read(a);
		ea = p ? sp + CPR_STACK_STEP : sp;
		sreg = '{wr: w, rd: r, addr: a, wdata: d};
		stk = '{push: p, pop: q};
		@(negedge clk);
		if (p || q)
			sp = p ? ea : sp - CPR_STACK_STEP;
		if (w && a == CPR_ADDR_STACK_TOP)
			sp = d;
		lo = (w && a == CPR_ADDR_PTR_LOW) ? d : lo;
		hi = (w && a == CPR_ADDR_PTR_HIGH) ? d : hi;
		pn = pn + 16'(p);
		qn = qn + 16'(q & ~p);
		if (r)
			check("read data", 16'(rdata), 16'(e[7:0]));
		check("read hit", 16'(hit), 16'(r & e[8]));
		if (p || q)
			check("stack address", 16'(saddr), 16'(ea));
		check("push strobe", 16'(swr), 16'(p));
		check("pop strobe", 16'(srd), 16'(q & ~p));
		check("pointer", data_pointer_16, {hi, lo});
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		{sp, lo, hi} = {CPR_RST_STACK_TOP, CPR_RST_PTR_LOW, CPR_RST_PTR_HIGH};
		{pn, qn} = '0;
		check("reset pointer", data_pointer_16, 16'h0000);
		check("reset stack address", 16'(saddr), 16'h0007);
		op(1'b0, 1'b1, 1'b0, 1'b0, CPR_ADDR_STACK_TOP, 8'h00);
		$display("test reset done");
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// about 150 cycles expected; cut off at 2000
	initial
	begin
		#20000;
		failures++;
		close_out();
	end
	initial
	begin
		do_reset();
		// wraparound, push over pop, read before same-cycle write
		op(1'b1, 1'b0, 1'b0, 1'b0, CPR_ADDR_STACK_TOP, 8'hff);
		op(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
		op(1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00);
		op(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		// pop at index zero wraps down to ff
		op(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		op(1'b1, 1'b1, 1'b0, 1'b0, CPR_ADDR_PTR_HIGH, 8'h5a);
		op(1'b1, 1'b0, 1'b0, 1'b0, CPR_ADDR_PTR_LOW, 8'hc3);
		// index load in the same cycle as a push: load wins, byte still written
		op(1'b1, 1'b0, 1'b1, 1'b0, CPR_ADDR_STACK_TOP, 8'h40);
		op(1'b0, 1'b1, 1'b0, 1'b0, CPR_ADDR_STACK_TOP, 8'h00);
		// software writes only zeros to reserved places
		// pointer is nonzero here, so an aliased decode would still show
		op(1'b1, 1'b1, 1'b0, 1'b0, 8'h84, 8'h00);
		op(1'b1, 1'b1, 1'b0, 1'b0, 8'h80, 8'h00);
		$display("test corners done");
		for (int i = 0; i < 120; i++)
		begin
			k = rnd();
			v = rnd();
			op(k[1:0] == 2'h0, k[1:0] == 2'h1, k[1:0] == 2'h2, k[1:0] == 2'h3,
				(k[4:3] == 2'h3) ? {v[7:2], 2'b00} : CPR_ADDR_STACK_TOP + 8'(k[4:3]),
				(k[4:3] == 2'h3) ? 8'h00 : v);
		end
		// one idle cycle so the partner counts the last strobe
		op(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		check("partner writes", wn, pn);
		check("partner reads", rn, qn);
		$display("test random done");
		do_reset();
		close_out();
	end
endmodule // cpr_pointer_regs_tb_top
